// ===== igx_pkg.sv
// constants, register layout and state codes for the eight-bit expander
package igx_pkg;

	// ************************************************************
	// register pointers
	// ************************************************************
	localparam logic [7:0] PTR_IN_LEVELS = 8'h00;
	localparam logic [7:0] PTR_OUT_LEVELS = 8'h01;
	localparam logic [7:0] PTR_POL_INVERT = 8'h02;
	localparam logic [7:0] PTR_DIRECTION = 8'h03;
	localparam logic [7:0] PTR_TIMEOUT = 8'h04;
	localparam logic [7:0] PTR_FACTORY = 8'hFF;

	// ************************************************************
	// reset values and fields
	// ************************************************************
	localparam logic [7:0] RST_OUT_LEVELS = 8'h00;
	localparam logic [7:0] RST_POL_INVERT = 8'hF0;
	localparam logic [7:0] RST_DIRECTION = 8'hFF;
	localparam logic [7:0] RST_TIMEOUT = 8'h01;
	localparam int TIMEOUT_ENABLE_POS = 0;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;

	// ************************************************************
	// timing
	// ************************************************************
	localparam longint CLK_HZ = 10_000_000;
	localparam longint TIMEOUT_MIN_MS = 30;
	localparam longint TIMEOUT_MAX_MS = 60;
	// least time, rounded up to whole cycles
	localparam int TIMEOUT_CYCLES = int'((TIMEOUT_MIN_MS * CLK_HZ + 999) / 1000);

	// ************************************************************
	// types
	// ************************************************************
	typedef struct packed {
		logic [7:0] timeout_ctl;
		logic [7:0] direction;
		logic [7:0] pol_invert;
		logic [7:0] out_levels;
	} igx_regs_s;

	localparam igx_regs_s RST_REGS = '{RST_TIMEOUT, RST_DIRECTION, RST_POL_INVERT,
		RST_OUT_LEVELS};

	typedef struct packed {
		logic start;
		logic stop;
		logic rise;
		logic fall;
	} igx_bus_ev_s;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_RX = 5'b00010,
		ST_RX_ACK = 5'b00100,
		ST_TX = 5'b01000,
		ST_TX_ACK = 5'b10000
	} igx_state_e;

endpackage : igx_pkg

// ===== igx_sync.sv
// three-stage input synchroniser with agreement filter, one per bit
`timescale 1ns/1ns
module igx_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] level
);

	// ************************************************************
	// per-bit chain
	// ************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			logic ff1_reg, ff2_reg, ff3_reg, lvl_reg;
			logic lvl_next;
			// a change counts only once stages two and three agree
			always_comb begin
				lvl_next = (ff2_reg == ff3_reg) ? ff3_reg : lvl_reg;
			end
			// ff1 feeds ff2 alone, so metastability never reaches logic
			always_ff @(posedge ref_clk or negedge nrst) begin
				if (!nrst) begin
					ff1_reg <= INIT[gi];
					ff2_reg <= INIT[gi];
					ff3_reg <= INIT[gi];
					lvl_reg <= INIT[gi];
				end else begin
					ff1_reg <= async_in[gi];
					ff2_reg <= ff1_reg;
					ff3_reg <= ff2_reg;
					lvl_reg <= lvl_next;
				end
			end
			assign level[gi] = lvl_reg;
		end
	endgenerate

endmodule : igx_sync

// ===== igx_strap.sv
// four-state address strap sensing and slave address forming
`timescale 1ns/1ns
module igx_strap (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [2:0] strap_lvl,
	input wire logic scl,
	input wire logic sda,
	output logic [6:0] slave_addr
);

	logic [2:0] moved;
	logic [2:0] low_bit;
	logic [2:0] bus_tied;
	logic [6:0] addr_next;
	logic [6:0] addr_reg;
	logic [2:0] settle_reg;
	logic [2:0] settle_next;
	logic armed;

	// ************************************************************
	// settle delay
	// ************************************************************
	// the sync chain shows its reset value for a few cycles; history taken then
	// would see a static strap move and mistake it for a bus line
	always_comb begin
		settle_next = settle_reg + {2'h0, ~armed};
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			settle_reg <= 3'h0;
		end else begin
			settle_reg <= settle_next;
		end
	end

	assign armed = &settle_reg;

	// ************************************************************
	// per-strap history since reset
	// ************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_strap
			logic seen_hi_reg, seen_lo_reg, ne_scl_reg;
			logic seen_hi_next, seen_lo_next, ne_scl_next;
			// a strap that has moved follows a bus line; differing from scl means sda
			always_comb begin
				seen_hi_next = seen_hi_reg | (armed & strap_lvl[gi]);
				seen_lo_next = seen_lo_reg | (armed & ~strap_lvl[gi]);
				ne_scl_next = ne_scl_reg | (armed & (strap_lvl[gi] ^ scl));
			end
			always_ff @(posedge ref_clk or negedge nrst) begin
				if (!nrst) begin
					seen_hi_reg <= 1'b0;
					seen_lo_reg <= 1'b0;
					ne_scl_reg <= 1'b0;
				end else begin
					seen_hi_reg <= seen_hi_next;
					seen_lo_reg <= seen_lo_next;
					ne_scl_reg <= ne_scl_next;
				end
			end
			assign moved[gi] = seen_hi_reg & seen_lo_reg;
			// supply and sda give a one, ground and scl a zero
			assign low_bit[gi] = moved[gi] ? ne_scl_reg : strap_lvl[gi];
		end
	endgenerate

	assign bus_tied = moved;

	always_comb begin
		addr_next[6] = 1'b0;
		addr_next[2:0] = low_bit;
		case (bus_tied)
			3'b010: addr_next[5:3] = 3'h1;
			3'b001: addr_next[5:3] = 3'h2;
			3'b000: addr_next[5:3] = 3'h3;
			3'b111: addr_next[5:3] = 3'h4;
			3'b110: addr_next[5:3] = 3'h5;
			3'b101: addr_next[5:3] = 3'h6;
			3'b100: addr_next[5:3] = 3'h7;
			default: addr_next[5:3] = 3'h0;
		endcase
	end

	// caught after reset release, never under reset
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			addr_reg <= 7'h00;
		end else begin
			addr_reg <= addr_next;
		end
	end

	assign slave_addr = addr_reg;

endmodule : igx_strap

// ===== igx_expander.sv
// eight-bit io expander: two-wire slave, pointer registers, bus timeout
// Summary of operation
// - output pins drive the stored output level bits
// - output register reads return stored bits, never pin levels
// - inversion bit set flips an input pin's reported level
// - direction one means input with driver off, zero means driven (pin 0 only while its output bit is low)
// - timeout register bit zero enables the bus timeout
// - stalled serial clock during our access resets the interface
// - line held low 30 to 60 ms resets the interface, never earlier
// - interface reset releases sda and waits for a new start
// - seven-bit address from three four-state straps, top bit zero
// - first byte after address is the register pointer
// - input level register is read-only, shows pins, writes discarded
// - reset pin low makes every pin an input
`timescale 1ns/1ns
module igx_expander #(
	parameter int TIMEOUT_CYC = igx_pkg::TIMEOUT_CYCLES,
	parameter int PINS = 8
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic addr_strap_0,
	input wire logic addr_strap_1,
	input wire logic addr_strap_2,
	input wire logic [PINS-1:0] port_pin_in,
	output logic [PINS-1:0] port_pin_out,
	output logic [PINS-1:0] port_pin_oe
);

	// ************************************************************
	// declarations
	// ************************************************************
	localparam logic [19:0] TMO_LAST = 20'(TIMEOUT_CYC - 1);

	logic [4:0] line_lvl;
	logic scl, sda;
	logic [2:0] strap_lvl;
	logic [PINS-1:0] pin_lvl;
	logic [6:0] slave_addr;
	logic scl_q_reg, sda_q_reg;
	igx_pkg::igx_bus_ev_s ev;

	igx_pkg::igx_state_e st_reg, st_next;
	logic [3:0] bit_reg, bit_next;
	logic [7:0] shift_reg, shift_next;
	logic [1:0] idx_reg, idx_next;
	logic rw_reg, rw_next;
	logic [7:0] ptr_reg, ptr_next;
	logic [7:0] tx_reg, tx_next;
	logic oe_reg, oe_next;
	logic mack_reg, mack_next;
	igx_pkg::igx_regs_s regs_reg, regs_next;
	logic [19:0] tmo_reg, tmo_next;
	logic tmo_fire;
	logic [7:0] rd_byte;
	logic [7:0] in_view;

	// ************************************************************
	// input sampling
	// ************************************************************
	// straps share the bus lines' chain depth so their comparison stays aligned
	igx_sync #(
		.WIDTH(5),
		.INIT(5'h03)
	) u_line_sync (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.async_in({addr_strap_2, addr_strap_1, addr_strap_0, sda_in, scl_in}),
		.level(line_lvl)
	);

	igx_sync #(
		.WIDTH(PINS),
		.INIT('0)
	) u_pin_sync (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.async_in(port_pin_in),
		.level(pin_lvl)
	);

	assign scl = line_lvl[0];
	assign sda = line_lvl[1];
	assign strap_lvl = line_lvl[4:2];

	igx_strap u_strap (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.strap_lvl(strap_lvl),
		.scl(scl),
		.sda(sda),
		.slave_addr(slave_addr)
	);

	// ************************************************************
	// bus events
	// ************************************************************
	// start and stop are sda moving while scl stays high
	always_comb begin
		ev.start = scl & scl_q_reg & sda_q_reg & ~sda;
		ev.stop = scl & scl_q_reg & ~sda_q_reg & sda;
		ev.rise = scl & ~scl_q_reg;
		ev.fall = ~scl & scl_q_reg;
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			scl_q_reg <= 1'b1;
			sda_q_reg <= 1'b1;
		end else begin
			scl_q_reg <= scl;
			sda_q_reg <= sda;
		end
	end

	// ************************************************************
	// read data
	// ************************************************************
	// inversion on input view
	assign in_view = pin_lvl ^ (regs_reg.pol_invert & regs_reg.direction);

	always_comb begin
		case (ptr_reg)
			igx_pkg::PTR_IN_LEVELS: rd_byte = in_view;
			igx_pkg::PTR_OUT_LEVELS: rd_byte = regs_reg.out_levels;
			igx_pkg::PTR_POL_INVERT: rd_byte = regs_reg.pol_invert;
			igx_pkg::PTR_DIRECTION: rd_byte = regs_reg.direction;
			igx_pkg::PTR_TIMEOUT: rd_byte = regs_reg.timeout_ctl;
			default: rd_byte = igx_pkg::READ_UNMAPPED;
		endcase
	end

	// ************************************************************
	// bus timeout
	// ************************************************************
	// stalled clock either level
	// counter restarts on every scl edge and fires at the 30 ms floor
	always_comb begin
		tmo_fire = 1'b0;
		tmo_next = 20'h00000;
		if (regs_reg.timeout_ctl[igx_pkg::TIMEOUT_ENABLE_POS] &&
			st_reg != igx_pkg::ST_IDLE && !ev.rise && !ev.fall) begin
			if (tmo_reg == TMO_LAST) begin
				tmo_fire = 1'b1;
			end else begin
				tmo_next = tmo_reg + 20'h00001;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tmo_reg <= 20'h00000;
		end else begin
			tmo_reg <= tmo_next;
		end
	end

	// ************************************************************
	// slave sequencer and register writes
	// ************************************************************
	always_comb begin
		st_next = st_reg;
		bit_next = bit_reg;
		shift_next = shift_reg;
		idx_next = idx_reg;
		rw_next = rw_reg;
		ptr_next = ptr_reg;
		tx_next = tx_reg;
		oe_next = oe_reg;
		mack_next = mack_reg;
		regs_next = regs_reg;
		if (tmo_fire) begin
			st_next = igx_pkg::ST_IDLE;
			oe_next = 1'b0;
		end else if (ev.start) begin
			// a repeated start restarts the frame from the address byte
			st_next = igx_pkg::ST_RX;
			bit_next = 4'h0;
			idx_next = 2'h0;
			oe_next = 1'b0;
		end else if (ev.stop) begin
			st_next = igx_pkg::ST_IDLE;
			oe_next = 1'b0;
		end else begin
			case (st_reg)
				igx_pkg::ST_RX: begin
					if (ev.rise) begin
						shift_next = {shift_reg[6:0], sda};
						bit_next = bit_reg + 4'h1;
					end else if (ev.fall && bit_reg == 4'h8) begin
						st_next = igx_pkg::ST_RX_ACK;
						oe_next = 1'b1;
						if (idx_reg == 2'h0) begin
							rw_next = shift_reg[0];
							if (shift_reg[7:1] != slave_addr) begin
								st_next = igx_pkg::ST_IDLE;
								oe_next = 1'b0;
							end
						end else if (idx_reg == 2'h1) begin
							ptr_next = shift_reg;
						end else begin
							// input register and unknown pointers drop writes
							case (ptr_reg)
								igx_pkg::PTR_OUT_LEVELS: regs_next.out_levels = shift_reg;
								igx_pkg::PTR_POL_INVERT: regs_next.pol_invert = shift_reg;
								igx_pkg::PTR_DIRECTION: regs_next.direction = shift_reg;
								igx_pkg::PTR_TIMEOUT: regs_next.timeout_ctl = shift_reg;
								default: regs_next = regs_reg;
							endcase
						end
					end
				end
				igx_pkg::ST_RX_ACK: begin
					if (ev.fall) begin
						oe_next = 1'b0;
						bit_next = 4'h0;
						st_next = igx_pkg::ST_RX;
						if (idx_reg != 2'h2) begin
							idx_next = idx_reg + 2'h1;
						end
						if (idx_reg == 2'h0 && rw_reg) begin
							st_next = igx_pkg::ST_TX;
							tx_next = rd_byte;
							oe_next = ~rd_byte[7];
						end
					end
				end
				igx_pkg::ST_TX: begin
					if (ev.fall) begin
						if (bit_reg == 4'h7) begin
							oe_next = 1'b0;
							st_next = igx_pkg::ST_TX_ACK;
						end else begin
							tx_next = {tx_reg[6:0], 1'b0};
							oe_next = ~tx_reg[6];
							bit_next = bit_reg + 4'h1;
						end
					end
				end
				igx_pkg::ST_TX_ACK: begin
					if (ev.rise) begin
						mack_next = ~sda;
					end else if (ev.fall) begin
						bit_next = 4'h0;
						if (mack_reg) begin
							st_next = igx_pkg::ST_TX;
							tx_next = rd_byte;
							oe_next = ~rd_byte[7];
						end else begin
							// not acknowledged: stay off the bus until stop or start
							st_next = igx_pkg::ST_IDLE;
						end
					end
				end
				default: begin
					st_next = igx_pkg::ST_IDLE;
					oe_next = 1'b0;
				end
			endcase
		end
	end

	// reset pin makes all pins inputs
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_reg <= igx_pkg::ST_IDLE;
			bit_reg <= 4'h0;
			shift_reg <= 8'h00;
			idx_reg <= 2'h0;
			rw_reg <= 1'b0;
			ptr_reg <= 8'h00;
			tx_reg <= 8'h00;
			oe_reg <= 1'b0;
			mack_reg <= 1'b0;
			regs_reg <= igx_pkg::RST_REGS;
		end else begin
			st_reg <= st_next;
			bit_reg <= bit_next;
			shift_reg <= shift_next;
			idx_reg <= idx_next;
			rw_reg <= rw_next;
			ptr_reg <= ptr_next;
			tx_reg <= tx_next;
			oe_reg <= oe_next;
			mack_reg <= mack_next;
			regs_reg <= regs_next;
		end
	end

	// ************************************************************
	// pin drive
	// ************************************************************
	// sda is open drain: only ever pulled low
	assign sda_out = 1'b0;
	assign sda_oe = oe_reg;

	assign port_pin_out = regs_reg.out_levels;

	// direction gates the driver; pin 0 is open drain, driving only a low
	always_comb begin
		port_pin_oe = ~regs_reg.direction;
		port_pin_oe[0] = ~regs_reg.direction[0] & ~regs_reg.out_levels[0];
	end

endmodule : igx_expander

// ===== igx_props.sv
// concurrent checks on the expander ports
`timescale 1ns/1ns
module igx_props #(
	parameter int TIMEOUT_CYC = 300000,
	parameter int PINS = 8
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic addr_strap_0,
	input wire logic addr_strap_1,
	input wire logic addr_strap_2,
	input wire logic [PINS-1:0] port_pin_in,
	input wire logic [PINS-1:0] port_pin_out,
	input wire logic [PINS-1:0] port_pin_oe
);
	logic [19:0] quiet_reg;
	logic [19:0] quiet_next;
	logic scl_d_reg;
	// cycles since scl last moved; saturates so a long idle never wraps
	always_comb begin
		quiet_next = quiet_reg + {19'h0, ~&quiet_reg};
		if (scl_in != scl_d_reg) begin
			quiet_next = 20'h0;
		end
	end
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			quiet_reg <= 20'h0;
			scl_d_reg <= 1'h1;
		end else begin
			quiet_reg <= quiet_next;
			scl_d_reg <= scl_in;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	AST_SDA_OUT_ZERO: assert property (sda_oe |-> sda_out == 1'h0)
		else $error("sda driven high");
	AST_DRIVE_AFTER_EDGE: assert property ($rose(sda_oe) |-> quiet_reg <= 20'h8)
		else $error("sda drive without scl edge");
	AST_DRIVE_HOLDS: assert property ($rose(sda_oe) |=> sda_oe [*4])
		else $error("sda drive too short");
	AST_RELEASE_TIME: assert property ($fell(sda_oe) |->
		(quiet_reg <= 20'h8 || quiet_reg >= TIMEOUT_CYC)) else $error("early release");
	AST_WRITE_ACKED: assert property ($changed(port_pin_out) |-> sda_oe)
		else $error("output register changed outside ack");
	AST_PINS_QUIET: assert property (($changed(port_pin_out) || $changed(port_pin_oe))
		|-> quiet_reg <= 20'h8) else $error("pins changed while bus idle");
	AST_BIT0_OPEN_DRAIN: assert property (port_pin_oe[0] |-> !port_pin_out[0])
		else $error("pin zero driven high");
	AST_RESET_INPUTS: assert property ($rose(nrst) |-> port_pin_oe == '0 && port_pin_out == '0)
		else $error("pins not inputs after reset");
	COV_TIMEOUT: cover property ($fell(sda_oe) && quiet_reg >= TIMEOUT_CYC);
	COV_WRITE: cover property ($changed(port_pin_out));
	COV_RESET: cover property ($rose(nrst));
endmodule : igx_props

// ===== igx_ctl_model.sv
// two-wire bus controller model: clocks scl, pulls sda low
`timescale 1ns/1ns
module igx_ctl_model (
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	// scl stands high between frames, sda released
	initial begin
		scl = 1'h1;
		sda_low = 1'h0;
	end
	// one 800 ns bit: the long low phase lets the slave's filtered sda drive
	// settle before it sees scl rise, else its own drive looks like start or stop
	task automatic clk_bit(input logic drv_low, output logic seen);
		#100 sda_low <= drv_low;
		#500 scl <= 1'h1;
		#100 seen = sda;
		#100 scl <= 1'h0;
	endtask : clk_bit
	// scl rises only after the slave has let go of a pending acknowledge
	task automatic start_cond();
		#100 sda_low <= 1'h0;
		#500 scl <= 1'h1;
		#400 sda_low <= 1'h1;
		#400 scl <= 1'h0;
	endtask : start_cond
	task automatic stop_cond();
		#100 sda_low <= 1'h1;
		#500 scl <= 1'h1;
		#400 sda_low <= 1'h0;
		#400;
	endtask : stop_cond
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(~b[i], s);
		end
		clk_bit(1'h0, s);
		ack = ~s;
	endtask : send_byte
	// master acks all but the last byte
	task automatic recv_byte(input logic last, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'h0, s);
			b[i] = s;
		end
		clk_bit(~last, s);
	endtask : recv_byte
	task automatic write_reg(input logic [6:0] a, input logic [7:0] p, d, output logic ok);
		logic k0, k1, k2;
		ok = 1'h0;
		if (p == igx_pkg::PTR_FACTORY) return;
		start_cond();
		send_byte({a, 1'h0}, k0);
		send_byte(p, k1);
		send_byte(d, k2);
		stop_cond();
		ok = k0 & k1 & k2;
	endtask : write_reg
	task automatic read_reg(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d,
		output logic ok);
		logic k0, k1, k2;
		start_cond();
		send_byte({a, 1'h0}, k0);
		send_byte(p, k1);
		start_cond();
		send_byte({a, 1'h1}, k2);
		recv_byte(1'h1, d);
		stop_cond();
		ok = k0 & k1 & k2;
	endtask : read_reg
endmodule : igx_ctl_model

// ===== testbench.sv
// self-checking bench: registers, pins, bus timeout and reset of the expander
`timescale 1ns/1ns
module testbench;
	localparam int TO_CYC = 200;
	logic ref_clk;
	logic nrst;
	logic [2:0] strap;
	logic [7:0] pins;
	logic [7:0] ovl;
	logic [7:0] pin_lvl;
	logic scl;
	logic sda_low;
	logic sda;
	logic sda_out;
	logic sda_oe;
	logic [7:0] port_pin_out;
	logic [7:0] port_pin_oe;
	logic [6:0] dev;
	int errors;
	int samples_checked;
	int cycles = 0;
	// wired-and sda with pull-up; ovl marks pins overpowered by the load
	assign sda = (sda_oe ? sda_out : 1'h1) & ~sda_low;
	assign pin_lvl = (port_pin_oe & port_pin_out & ~ovl) | ((~port_pin_oe | ovl) & pins);
	initial begin
		ref_clk = 1'h0;
		forever #50 ref_clk = ~ref_clk;
	end
	igx_expander #(.TIMEOUT_CYC(TO_CYC), .PINS(8)) uut (.ref_clk(ref_clk), .nrst(nrst),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.addr_strap_0(strap[0]), .addr_strap_1(strap[1]), .addr_strap_2(strap[2]),
		.port_pin_in(pin_lvl), .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe));
	igx_ctl_model ctl (.scl(scl), .sda_low(sda_low), .sda(sda));
	// ************************************************************
	// shared checks and bus cycles
	// ************************************************************
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test
	task automatic check(input string what, input logic [7:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [7:0] p, d);
		logic ok;
		ctl.write_reg(dev, p, d, ok);
		check("write ack", {7'h0, ok}, 8'h01);
	endtask : wr
	task automatic rd_chk(input string what, input logic [7:0] p, exp);
		logic ok;
		logic [7:0] d;
		ctl.read_reg(dev, p, d, ok);
		check("read ack", {7'h0, ok}, 8'h01);
		check(what, d, exp);
	endtask : rd_chk
	// address byte clocked, then scl parked low in the ack slot
	task automatic stall_addr();
		logic s;
		logic [7:0] b;
		b = {dev, 1'h0};
		ctl.start_cond();
		for (int i = 7; i >= 0; i--) begin
			ctl.clk_bit(~b[i], s);
		end
		repeat (150) @(posedge ref_clk);
		check("drive before min", {7'h0, sda_oe}, 8'h01);
		repeat (100) @(posedge ref_clk);
	endtask : stall_addr
	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_defaults();
		check("oe at reset", port_pin_oe, 8'h00);
		rd_chk("out reset", igx_pkg::PTR_OUT_LEVELS, 8'h00);
		rd_chk("inv reset", igx_pkg::PTR_POL_INVERT, 8'hF0);
		rd_chk("dir reset", igx_pkg::PTR_DIRECTION, 8'hFF);
		rd_chk("timeout reset", igx_pkg::PTR_TIMEOUT, 8'h01);
		$display("test defaults done");
	endtask : t_defaults
	task automatic t_outputs();
		pins <= 8'h5A;
		wr(8'h03, 8'h00);
		wr(8'h01, 8'hA5);
		check("pin out", port_pin_out, 8'hA5);
		check("pin oe", port_pin_oe, 8'hFE);
		rd_chk("in levels", 8'h00, 8'hA4);
		wr(8'h00, 8'hFF);
		rd_chk("in after write", 8'h00, 8'hA4);
		ovl <= 8'hFF;
		rd_chk("out overloaded", 8'h01, 8'hA5);
		rd_chk("in overloaded", 8'h00, 8'h5A);
		ovl <= 8'h00;
		wr(8'h01, 8'h5A);
		check("pin oe low out", port_pin_oe, 8'hFF);
		wr(8'h03, 8'hFF);
		check("pin oe inputs", port_pin_oe, 8'h00);
		$display("test outputs done");
	endtask : t_outputs
	task automatic t_invert();
		pins <= 8'h33;
		wr(8'h02, 8'h0F);
		rd_chk("in inverted", 8'h00, 8'h3C);
		wr(8'h02, 8'h00);
		rd_chk("in plain", 8'h00, 8'h33);
		wr(8'h02, 8'hFF);
		wr(8'h03, 8'hF0);
		rd_chk("invert inputs only", 8'h00, 8'hCA);
		wr(8'h03, 8'hFF);
		$display("test invert done");
	endtask : t_invert
	task automatic t_unmapped();
		logic ok;
		wr(8'h05, 8'h77);
		rd_chk("unmapped read", 8'h05, igx_pkg::READ_UNMAPPED);
		ctl.write_reg(dev ^ 7'h01, 8'h01, 8'hFF, ok);
		check("foreign address ack", {7'h0, ok}, 8'h00);
		rd_chk("out untouched", 8'h01, 8'h5A);
		$display("test unmapped done");
	endtask : t_unmapped
	task automatic t_timeout();
		logic s;
		stall_addr();
		check("released by timeout", {7'h0, sda_oe}, 8'h00);
		// a slave still in its ack slot would pull the first released bit low
		for (int i = 0; i < 9; i++) begin
			ctl.clk_bit(i[0], s);
			if (!i[0]) check("ignored until start", {7'h0, s}, 8'h01);
		end
		ctl.stop_cond();
		wr(8'h04, 8'h00);
		stall_addr();
		check("timeout disabled", {7'h0, sda_oe}, 8'h01);
		ctl.clk_bit(1'h0, s);
		ctl.stop_cond();
		wr(8'h04, 8'h01);
		rd_chk("alive after stall", 8'h04, 8'h01);
		$display("test timeout done");
	endtask : t_timeout
	task automatic t_reset();
		logic ok;
		wr(8'h03, 8'h00);
		@(posedge ref_clk);
		nrst <= 1'h0;
		strap <= 3'h7;
		@(posedge ref_clk);
		check("oe in reset", port_pin_oe, 8'h00);
		repeat (3) @(posedge ref_clk);
		nrst <= 1'h1;
		dev = 7'h1F;
		repeat (10) @(posedge ref_clk);
		rd_chk("dir after reset", 8'h03, 8'hFF);
		rd_chk("out after reset", 8'h01, 8'h00);
		ctl.write_reg(7'h18, 8'h01, 8'hFF, ok);
		check("old address ack", {7'h0, ok}, 8'h00);
		$display("test reset done");
	endtask : t_reset
	// hang guard: runs far past the expected length
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			errors++;
			finish_test();
		end
	end
	initial begin
		nrst = 1'h0;
		strap = 3'h0;
		pins = 8'h00;
		ovl = 8'h00;
		errors = 0;
		samples_checked = 0;
		dev = 7'h18;
		repeat (4) @(posedge ref_clk);
		nrst <= 1'h1;
		repeat (10) @(posedge ref_clk);
		t_defaults();
		t_outputs();
		t_invert();
		t_unmapped();
		t_timeout();
		t_reset();
		finish_test();
	end
endmodule : testbench
bind igx_expander igx_props #(.TIMEOUT_CYC(TIMEOUT_CYC), .PINS(PINS)) props (.ref_clk(ref_clk),
	.nrst(nrst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.addr_strap_0(addr_strap_0), .addr_strap_1(addr_strap_1), .addr_strap_2(addr_strap_2),
	.port_pin_in(port_pin_in), .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe));
